// [dv/csc_card_model.sv]
`timescale 1ns/10ps
module csc_card_model
  import csc_pkg::*;
(
  input wire logic clk,
  output logic card_detect_a_n,
  output logic card_detect_b_n,
  output logic ready,
  output logic battery_voltage_detect_1,
  output logic battery_voltage_detect_2,
  output logic card_state_change_n,
  output logic ring_indicate
);
  // The card idles inserted, busy, with good batteries and no status change.
  logic [CSC_IN_W-1:0] pins_q = 7'h0E;

  assign card_detect_a_n = pins_q[CSC_IN_CD_A];
  assign card_detect_b_n = pins_q[CSC_IN_CD_B];
  assign ready = pins_q[CSC_IN_READY];
  assign battery_voltage_detect_1 = pins_q[CSC_IN_BATV1];
  assign battery_voltage_detect_2 = pins_q[CSC_IN_BATV2];
  assign card_state_change_n = pins_q[CSC_IN_CHG];
  assign ring_indicate = pins_q[CSC_IN_RING];

  // Pins move just after a rising edge, as a real card's lines would settle.
  task automatic set_pin(input int lane, input logic v);
    @(posedge clk);
    pins_q[lane] <= v;
  endtask
endmodule // csc_card_model

// [dv/tb_top.sv]
`timescale 1ns/10ps
`define CHK(got, exp) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) \
    begin \
      fails++; \
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp); \
    end \
  end
module tb_top
  import csc_pkg::*;
;
  localparam logic [11:0] ST = CSC_IDX_STATUS;
  localparam logic [11:0] CF = CSC_IDX_CONFIG;
  localparam logic [11:0] CT = CSC_IDX_CTRL;
  logic clk;
  logic rst;
  logic psel;
  logic penable;
  logic pwrite;
  logic [CSC_ADDR_W-1:0] paddr;
  logic [CSC_DATA_W-1:0] pwdata;
  logic [3:0] pstrb;
  logic [CSC_DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  logic card_detect_a_n;
  logic card_detect_b_n;
  logic ready;
  logic battery_voltage_detect_1;
  logic battery_voltage_detect_2;
  logic card_state_change_n;
  logic ring_indicate;
  csc_irq_t irq;
  int fails;
  int n_compared;

  csc_irq #(.SOCKET_B(1'b0)) uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .card_detect_a_n(card_detect_a_n),
    .card_detect_b_n(card_detect_b_n), .ready(ready),
    .battery_voltage_detect_1(battery_voltage_detect_1),
    .battery_voltage_detect_2(battery_voltage_detect_2),
    .card_state_change_n(card_state_change_n), .ring_indicate(ring_indicate), .irq(irq));

  csc_card_model card (.clk(clk), .card_detect_a_n(card_detect_a_n),
    .card_detect_b_n(card_detect_b_n), .ready(ready),
    .battery_voltage_detect_1(battery_voltage_detect_1),
    .battery_voltage_detect_2(battery_voltage_detect_2),
    .card_state_change_n(card_state_change_n), .ring_indicate(ring_indicate));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [CSC_ADDR_W-1:0] ba(input logic [11:0] idx);
    return {idx, 2'b00};
  endfunction

  task automatic stop_test();
    if (fails == 0 && n_compared > 0)
    begin
      $display("Test passed");
    end
    else
    begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [13:0] a, input logic [7:0] d,
                     input logic [3:0] s, output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 16)
    begin
      @(posedge clk);
      n++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16)
    begin
      fails++;
      stop_test();
    end
  endtask

  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, ba(idx), d, 4'hF, rd, err);
  endtask

  task automatic rchk(input logic [11:0] idx, input logic [7:0] e);
    logic [31:0] rd;
    logic err;
    logic [31:0] ex;
    ex = {24'h000000, e};
    apb(1'b0, ba(idx), 8'h00, 4'h0, rd, err);
    `CHK(rd, ex)
  endtask

  // Waits well past the synchroniser and flag latency before anything is read.
  task automatic pin(input int lane, input logic v);
    card.set_pin(lane, v);
    repeat (6) @(posedge clk);
  endtask

  task automatic t_reset();
    `CHK(irq, 18'h00000)
    rchk(ST, 8'h00);
    rchk(CF, 8'h00);
    rchk(CT, 8'h00);
  endtask

  task automatic t_card_detect();
    logic [31:0] rd;
    logic err;
    pin(CSC_IN_CD_A, 1'b1);
    rchk(ST, 8'h00);
    wr(CF, 8'h38);
    pin(CSC_IN_CD_B, 1'b1);
    `CHK(irq, 18'h00008)
    apb(1'b0, ba(CSC_IDX_ROUTE), 8'h00, 4'h0, rd, err);
    `CHK(rd, 32'h00040008)
    repeat (20) @(posedge clk);
    rchk(CSC_IDX_LEG_STATUS_A, 8'h08);
    rchk(ST, 8'h00);
    repeat (2) @(posedge clk);
    `CHK(irq, 18'h00000)
  endtask

  task automatic t_w1c();
    logic [31:0] rd;
    logic err;
    wr(CT, 8'h04);
    pin(CSC_IN_CD_A, 1'b0);
    rchk(ST, 8'h08);
    rchk(ST, 8'h08);
    apb(1'b1, ba(ST), 8'h08, 4'h0, rd, err);
    wr(ST, 8'h00);
    rchk(ST, 8'h08);
    wr(ST, 8'h08);
    rchk(ST, 8'h00);
  endtask

  task automatic t_route();
    pin(CSC_IN_CD_B, 1'b0);
    for (int c = 1; c < 16; c++)
    begin
      wr(CF, {c[3:0], 4'h8});
      repeat (2) @(posedge clk);
      `CHK(irq, (c == 2) ? 18'h10000 : (18'h00001 << c))
    end
    wr(CF, 8'h08);
    repeat (2) @(posedge clk);
    `CHK(irq, 18'h00000)
    wr(CT, 8'h14);
    repeat (2) @(posedge clk);
    `CHK(irq, 18'h20000)
    wr(CT, 8'h05);
    repeat (2) @(posedge clk);
    `CHK(irq, 18'h20000)
    wr(CF, 8'h38);
    wr(CT, 8'h14);
    repeat (2) @(posedge clk);
    `CHK(irq, 18'h20000)
    wr(CT, 8'h04);
    wr(ST, 8'h08);
    rchk(ST, 8'h00);
    wr(CT, 8'h00);
  endtask

  task automatic t_memory();
    int lane[3];
    logic lvl[3];
    logic [7:0] e[3];
    lane = '{CSC_IN_READY, CSC_IN_BATV2, CSC_IN_BATV1};
    lvl = '{1'b1, 1'b0, 1'b0};
    e = '{8'h04, 8'h02, 8'h01};
    wr(CF, 8'h27);
    for (int i = 0; i < 3; i++)
    begin
      pin(lane[i], lvl[i]);
      `CHK(irq, 18'h10000)
      rchk(ST, e[i]);
    end
    pin(CSC_IN_READY, 1'b0);
    pin(CSC_IN_BATV2, 1'b1);
    pin(CSC_IN_BATV1, 1'b1);
    rchk(ST, 8'h00);
    wr(CF, 8'h23);
    pin(CSC_IN_READY, 1'b1);
    rchk(ST, 8'h00);
    pin(CSC_IN_READY, 1'b0);
  endtask

  task automatic t_io();
    wr(CT, 8'h20);
    wr(CF, 8'h27);
    pin(CSC_IN_READY, 1'b1);
    pin(CSC_IN_BATV2, 1'b0);
    rchk(ST, 8'h00);
    pin(CSC_IN_CHG, 1'b0);
    rchk(ST, 8'h01);
    pin(CSC_IN_READY, 1'b0);
    pin(CSC_IN_BATV2, 1'b1);
    pin(CSC_IN_CHG, 1'b1);
    wr(CT, 8'h00);
  endtask

  task automatic t_ring();
    wr(CT, 8'h80);
    wr(CF, 8'h01);
    pin(CSC_IN_RING, 1'b1);
    rchk(ST, 8'h01);
    pin(CSC_IN_RING, 1'b0);
    rchk(ST, 8'h00);
    rchk(CSC_IDX_LEG_CONFIG_A, 8'h01);
    wr(CT, 8'h00);
  endtask

  task automatic t_unmapped();
    logic [31:0] rd;
    logic err;
    apb(1'b0, ba(12'h807), 8'h00, 4'h0, rd, err);
    `CHK(err, 1'b1)
    `CHK(rd, 32'h00000000)
  endtask

  initial
  begin
    fails = 0;
    n_compared = 0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'h0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_reset();
    t_card_detect();
    t_w1c();
    t_route();
    t_memory();
    t_io();
    t_ring();
    t_unmapped();
    stop_test();
  end
endmodule // tb_top

// [rtl/csc_irq.sv]
// Overview of operation
// [R01] An enabled status-change source becoming active raises the routed host interrupt.
// [R02] A flag whose source is disabled always reads zero.
// [R03] Enabled source activity sets its flag; it stays set until software clears it.
// [R04] Flags clear on status read or on write-one, chosen by the clear-mode bit.
// [R05] Service software reads status to find the source, then clears handled flags.
// [R06] Status bits seven to four are reserved and read zero.
// [R07] Status bit 3 sets on a change of either card-detect line.
// [R08] Memory card: status bit 2 sets on a rising edge of ready.
// [R09] Memory card: status bit 1 sets on a battery-low warning.
// [R10] Memory card: status bit 0 reports battery dead, set on a falling edge of battery_voltage_detect_1.
// [R11] I/O card: ready and battery-warning status bits are forced to zero.
// [R12] Ring-indicate mode: status bit 0 reports the ring-indicate level.
// [R13] Config route field picks IRQ1, SMI on code 2, or the numbered legacy IRQ.
// [R14] Route 0 with the diagnostic bit set routes to PCI, ignoring the PCI-route bit.
// [R15] Route 0 with diagnostic clear: no legacy IRQ; PCI only if PCI-route bit set.
// [R16] Config bit 3 enables interrupts on card-detect changes.
// [R17] Config bit 2 enables ready rising edges as a status-change interrupt.
// [R18] Config bit 1 enables battery-warning interrupts.
// [R19] Config bit 0 enables battery dead, or change-line assertion on I/O cards.
// [R20] Status and configuration registers reset to all zeros.
// [R21] Status register sits at index 804h, legacy 04h or 44h.
// [R22] Configuration register sits at index 805h, legacy 05h or 45h.
// [R23] Ring-indicate operation is enabled by the ring-indicate enable control bit.
// [R24] PCI-route control bit set sends status-change interrupts to PCI.
// [R25] Card-type control bit selects memory-card or I/O-card meaning of status bits.
// [R26] Card inputs are synchronised; the selected interrupt holds while enabled flags remain.
// [R27] Write-one is ignored in read-clear mode; reads have no effect in write-one mode.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/10ps
module csc_irq
  import csc_pkg::*;
#(
  parameter bit SOCKET_B = 1'b0
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [CSC_ADDR_W-1:0] paddr,
  input wire logic [CSC_DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [CSC_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic card_detect_a_n,
  input wire logic card_detect_b_n,
  input wire logic ready,
  input wire logic battery_voltage_detect_1,
  input wire logic battery_voltage_detect_2,
  input wire logic card_state_change_n,
  input wire logic ring_indicate,
  output csc_irq_t irq
);

  localparam logic [11:0] LEG_STATUS = SOCKET_B ? CSC_IDX_LEG_STATUS_B : CSC_IDX_LEG_STATUS_A;
  localparam logic [11:0] LEG_CONFIG = SOCKET_B ? CSC_IDX_LEG_CONFIG_B : CSC_IDX_LEG_CONFIG_A;

  logic [CSC_IN_W-1:0] pins;
  logic [CSC_IN_W-1:0] sync1_q;
  logic [CSC_IN_W-1:0] sync2_q;
  logic [CSC_IN_W-1:0] prev_q;
  logic [1:0] arm_q;
  logic [1:0] arm_d;
  logic armed;

  csc_config_t cfg_q;
  csc_config_t cfg_d;
  csc_ctrl_t ctrl_q;
  csc_ctrl_t ctrl_d;
  logic [3:0] flags_q;
  logic [3:0] flags_d;
  logic [3:0] set_ev;
  logic [3:0] clr;
  logic [3:0] en_mask;
  logic [7:0] status_view;
  logic pending;
  csc_irq_t irq_d;

  logic [CSC_DATA_W-1:0] prdata_d;
  logic pready_d;
  logic pslverr_d;
  csc_sel_t sel;
  logic setup;
  logic done;

  logic cd_change;
  logic ready_rise;
  logic batlow_ev;
  logic dead_ev;
  logic ring_lvl;

  // Card pins are asynchronous; only the second stage and its delayed copy are used.
  assign pins[CSC_IN_CD_A] = card_detect_a_n;
  assign pins[CSC_IN_CD_B] = card_detect_b_n;
  assign pins[CSC_IN_READY] = ready;
  assign pins[CSC_IN_BATV1] = battery_voltage_detect_1;
  assign pins[CSC_IN_BATV2] = battery_voltage_detect_2;
  assign pins[CSC_IN_CHG] = card_state_change_n;
  assign pins[CSC_IN_RING] = ring_indicate;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q <= '0;
    end
    else
    begin
      sync1_q <= pins; // R26
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  // Edge detection is held off until the delayed copy holds real pin levels.
  always_comb
  begin
    arm_d = arm_q;
    if (arm_q != 2'h3)
    begin
      arm_d = arm_q + 2'h1;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      arm_q <= 2'h0;
    end
    else
    begin
      arm_q <= arm_d;
    end
  end

  assign armed = (arm_q == 2'h3);

  always_comb
  begin
    cd_change = armed && ((sync2_q[CSC_IN_CD_A] ^ prev_q[CSC_IN_CD_A])
                || (sync2_q[CSC_IN_CD_B] ^ prev_q[CSC_IN_CD_B])); // R07
    ready_rise = armed && sync2_q[CSC_IN_READY] && !prev_q[CSC_IN_READY]; // R08
    batlow_ev = armed && !sync2_q[CSC_IN_BATV2] && prev_q[CSC_IN_BATV2]; // R09
    if (ctrl_q.io_card_select)
    begin
      dead_ev = armed && !sync2_q[CSC_IN_CHG] && prev_q[CSC_IN_CHG]; // R19
    end
    else
    begin
      dead_ev = armed && !sync2_q[CSC_IN_BATV1] && prev_q[CSC_IN_BATV1]; // R10
    end
    ring_lvl = ctrl_q.ring_indicate_enable && sync2_q[CSC_IN_RING]; // R23
  end

  always_comb
  begin
    if (csc_hit(paddr, CSC_IDX_STATUS) || csc_hit(paddr, LEG_STATUS)) // R21
    begin
      sel = CSC_SEL_STATUS;
    end
    else if (csc_hit(paddr, CSC_IDX_CONFIG) || csc_hit(paddr, LEG_CONFIG)) // R22
    begin
      sel = CSC_SEL_CONFIG;
    end
    else if (csc_hit(paddr, CSC_IDX_CTRL))
    begin
      sel = CSC_SEL_CTRL;
    end
    else if (csc_hit(paddr, CSC_IDX_ROUTE))
    begin
      sel = CSC_SEL_ROUTE;
    end
    else
    begin
      sel = CSC_SEL_NONE;
    end
  end

  assign setup = psel && !penable;
  assign done = psel && penable && pready;

  // Read data is captured in the setup cycle and presented during the access phase.
  always_comb
  begin
    prdata_d = '0;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    if (setup)
    begin
      pready_d = 1'b1;
      pslverr_d = (sel == CSC_SEL_NONE);
      if (!pwrite)
      begin
        if (sel == CSC_SEL_STATUS)
        begin
          prdata_d = {24'h000000, status_view};
        end
        else if (sel == CSC_SEL_CONFIG)
        begin
          prdata_d = {24'h000000, cfg_q};
        end
        else if (sel == CSC_SEL_CTRL)
        begin
          prdata_d = {24'h000000, ctrl_q};
        end
        else if (sel == CSC_SEL_ROUTE)
        begin
          prdata_d = {13'h0000, pending, irq};
        end
      end
    end
    else if (psel && penable && !pready)
    begin
      pready_d = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      prdata <= prdata_d;
      pready <= pready_d;
      pslverr <= pslverr_d;
    end
  end

  // Configuration and control registers; byte lane 0 carries all their bits.
  always_comb
  begin
    cfg_d = cfg_q;
    ctrl_d = ctrl_q;
    if (done && pwrite && pstrb[0])
    begin
      if (sel == CSC_SEL_CONFIG)
      begin
        cfg_d = csc_config_t'(pwdata[7:0]);
      end
      else if (sel == CSC_SEL_CTRL)
      begin
        ctrl_d = csc_ctrl_t'(pwdata[7:0]);
        ctrl_d.rsvd6 = 1'b0;
        ctrl_d.rsvd3 = 1'b0;
        ctrl_d.rsvd1 = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cfg_q <= csc_config_t'(CSC_CONFIG_RST); // R20
      ctrl_q <= csc_ctrl_t'(CSC_CTRL_RST);
    end
    else
    begin
      cfg_q <= cfg_d;
      ctrl_q <= ctrl_d;
    end
  end

  always_comb
  begin
    en_mask[CSC_ST_CD] = cfg_q.card_detect_irq_enable; // R16
    en_mask[CSC_ST_READY] = cfg_q.ready_irq_enable && !ctrl_q.io_card_select; // R17 R11 R25
    en_mask[CSC_ST_BATLOW] = cfg_q.battery_low_irq_enable && !ctrl_q.io_card_select; // R18 R11
    en_mask[CSC_ST_DEAD] = cfg_q.battery_dead_irq_enable && !ctrl_q.ring_indicate_enable; // R19
    set_ev = {cd_change, ready_rise, batlow_ev, dead_ev};
    clr = 4'h0;
    if (done && sel == CSC_SEL_STATUS)
    begin
      if (ctrl_q.flag_clear_w1c && pwrite && pstrb[0])
      begin
        clr = pwdata[3:0]; // R04 R27
      end
      else if (!ctrl_q.flag_clear_w1c && !pwrite)
      begin
        clr = prdata[3:0]; // R04 R27
      end
    end
    // A set in the clearing cycle wins; a disabled source drops its flag.
    flags_d = ((flags_q & ~clr) | set_ev) & en_mask; // R03 R02
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      flags_q <= CSC_STATUS_RST[3:0]; // R20
    end
    else
    begin
      flags_q <= flags_d;
    end
  end

  always_comb
  begin
    status_view = {4'h0, flags_q}; // R06
    if (ctrl_q.ring_indicate_enable)
    begin
      status_view[CSC_ST_DEAD] = ring_lvl && cfg_q.battery_dead_irq_enable; // R12
    end
  end

  assign pending = |status_view[3:0]; // R01

  always_comb
  begin
    irq_d = '0;
    if ((cfg_q.status_change_irq_route == CSC_ROUTE_NONE && ctrl_q.diag_status_change_pci)
        || ctrl_q.status_change_pci_route) // R14 R15 R24
    begin
      irq_d.pci = pending;
    end
    else if (cfg_q.status_change_irq_route == CSC_ROUTE_SMI)
    begin
      irq_d.smi = pending; // R13
    end
    else if (cfg_q.status_change_irq_route != CSC_ROUTE_NONE)
    begin
      irq_d.isa[cfg_q.status_change_irq_route] = pending; // R13
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      irq <= '0;
    end
    else
    begin
      irq <= irq_d; // R26
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_reserved_reads_zero: assert property ( // R06
    (done && !pwrite && sel == CSC_SEL_STATUS) |-> prdata[7:4] == 4'h0)
    else $error("Reserved status bits read nonzero.");
  a_disabled_flag_zero: assert property ( // R02
    (!cfg_q.card_detect_irq_enable && !$past(cfg_q.card_detect_irq_enable))
      |-> !flags_q[CSC_ST_CD])
    else $error("Card-detect flag set while its source is disabled.");
  a_cd_change_sets: assert property ( // R07
    (cd_change && cfg_q.card_detect_irq_enable && cfg_d.card_detect_irq_enable)
      |=> flags_q[CSC_ST_CD])
    else $error("Card-detect change did not set its flag.");
  a_ready_rise_sets: assert property ( // R08
    (ready_rise && en_mask[CSC_ST_READY] && cfg_d.ready_irq_enable
      && !ctrl_d.io_card_select) |=> flags_q[CSC_ST_READY])
    else $error("Ready rising edge did not set its flag.");
  a_flag_holds: assert property ( // R03
    (flags_q[CSC_ST_CD] && clr[CSC_ST_CD] == 1'b0 && cfg_q.card_detect_irq_enable)
      |=> flags_q[CSC_ST_CD])
    else $error("Card-detect flag dropped without a clear.");
  a_io_forces_zero: assert property ( // R11
    (ctrl_q.io_card_select && $past(ctrl_q.io_card_select))
      |-> flags_q[CSC_ST_READY:CSC_ST_BATLOW] == 2'b00)
    else $error("Ready or battery-warning flag set with an I/O card.");
  a_read_clears: assert property ( // R04
    (done && !pwrite && sel == CSC_SEL_STATUS && !ctrl_q.flag_clear_w1c
      && set_ev == 4'h0 && !ctrl_q.ring_indicate_enable)
      |=> (flags_q & $past(prdata[3:0])) == 4'h0)
    else $error("Status read did not clear the returned flags.");
  a_w1c_read_keeps: assert property ( // R27
    (done && !pwrite && sel == CSC_SEL_STATUS && ctrl_q.flag_clear_w1c && set_ev == 4'h0)
      |=> flags_q == $past(flags_q))
    else $error("Status read changed flags in write-one-clear mode.");
  a_pci_route_diag: assert property ( // R14
    (pending && cfg_q.status_change_irq_route == CSC_ROUTE_NONE
      && ctrl_q.diag_status_change_pci) |=> irq.pci)
    else $error("Pending status change not routed to PCI.");
  a_route_none_quiet: assert property ( // R15
    (cfg_q.status_change_irq_route == CSC_ROUTE_NONE && !ctrl_q.diag_status_change_pci
      && !ctrl_q.status_change_pci_route) |=> (irq == '0))
    else $error("Interrupt driven with no route selected.");
  a_legacy_route: assert property ( // R13
    (pending && cfg_q.status_change_irq_route == 4'h5 && !ctrl_q.status_change_pci_route)
      |=> irq.isa[5] && !irq.smi && !irq.pci)
    else $error("Legacy IRQ 5 not asserted for route code 5.");

endmodule // csc_irq

// [rtl/csc_pkg.sv]
package csc_pkg;

  // Register bus geometry: each register index sits at byte address index * 4.
  localparam int CSC_ADDR_W = 14;
  localparam int CSC_DATA_W = 32;

  // Register indices in socket space and in the legacy index space.
  localparam logic [11:0] CSC_IDX_STATUS = 12'h804;
  localparam logic [11:0] CSC_IDX_CONFIG = 12'h805;
  localparam logic [11:0] CSC_IDX_CTRL = 12'h810;
  localparam logic [11:0] CSC_IDX_ROUTE = 12'h811;
  localparam logic [11:0] CSC_IDX_LEG_STATUS_A = 12'h004;
  localparam logic [11:0] CSC_IDX_LEG_STATUS_B = 12'h044;
  localparam logic [11:0] CSC_IDX_LEG_CONFIG_A = 12'h005;
  localparam logic [11:0] CSC_IDX_LEG_CONFIG_B = 12'h045;

  // Status flag positions.
  localparam int CSC_ST_CD = 3;
  localparam int CSC_ST_READY = 2;
  localparam int CSC_ST_BATLOW = 1;
  localparam int CSC_ST_DEAD = 0;

  // Reset values.
  localparam logic [7:0] CSC_STATUS_RST = 8'h00;
  localparam logic [7:0] CSC_CONFIG_RST = 8'h00;
  localparam logic [7:0] CSC_CTRL_RST = 8'h00;

  // Routing codes with a special meaning.
  localparam logic [3:0] CSC_ROUTE_NONE = 4'h0;
  localparam logic [3:0] CSC_ROUTE_SMI = 4'h2;

  // Synchroniser lanes for the card inputs.
  localparam int CSC_IN_CD_A = 6;
  localparam int CSC_IN_CD_B = 5;
  localparam int CSC_IN_READY = 4;
  localparam int CSC_IN_BATV1 = 3;
  localparam int CSC_IN_BATV2 = 2;
  localparam int CSC_IN_CHG = 1;
  localparam int CSC_IN_RING = 0;
  localparam int CSC_IN_W = 7;

  typedef struct packed {
    logic [3:0] status_change_irq_route;
    logic card_detect_irq_enable;
    logic ready_irq_enable;
    logic battery_low_irq_enable;
    logic battery_dead_irq_enable;
  } csc_config_t;

  typedef struct packed {
    logic ring_indicate_enable;
    logic rsvd6;
    logic io_card_select;
    logic status_change_pci_route;
    logic rsvd3;
    logic flag_clear_w1c;
    logic rsvd1;
    logic diag_status_change_pci;
  } csc_ctrl_t;

  typedef struct packed {
    logic pci;
    logic smi;
    logic [15:0] isa;
  } csc_irq_t;

  typedef enum {CSC_SEL_NONE, CSC_SEL_STATUS, CSC_SEL_CONFIG, CSC_SEL_CTRL, CSC_SEL_ROUTE} csc_sel_t;

  // Byte-address match of an APB address against a register index.
  function automatic logic csc_hit(logic [CSC_ADDR_W-1:0] addr, logic [11:0] idx);
    return addr == {idx, 2'b00};
  endfunction

endpackage
